// ---- include/abie_pkg.sv ----
// constants, types and decode helpers for the add and branch executor
package abie_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_INSTR = 8'h04;
   localparam logic [7:0] OFF_WORK = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_BANK = 8'h10;
   localparam logic [7:0] OFF_PC = 8'h14;
   localparam logic [7:0] OFF_FSR = 8'h18;
   localparam logic [7:0] OFF_MADDR = 8'h1c;
   localparam logic [7:0] OFF_MDATA = 8'h20;
   localparam logic [7:0] OFF_STATE = 8'h24;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ------------------------------------------------------------
   // reset values and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [20:0] PC_RST = 21'h000000;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [11:0] FSR_RST = 12'h000;
   localparam logic [15:0] INSTR_RST = 16'h0000;
   localparam int CTRL_EXT_POS = 0;
   localparam int DEST_POS = 9;
   localparam int ACC_POS = 8;
   localparam int BIT_POS = 9;
   localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   // ------------------------------------------------------------
   // opcodes
   // ------------------------------------------------------------
   localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
   localparam logic [7:0] OPC_AND_LIT = 8'h0b;
   localparam logic [5:0] OPC_AND_FILE = 6'h05;
   localparam logic [3:0] OPC_CLR_BIT = 4'h9;
   localparam logic [7:0] OPC_BR_CSET = 8'he2;
   localparam logic [7:0] OPC_BR_CCLR = 8'he3;
   localparam logic [7:0] OPC_BR_NSET = 8'he6;
   localparam logic [7:0] OPC_BR_NCLR = 8'he7;

   typedef enum logic [3:0] {
      ABIE_OP_NONE, ABIE_OP_ADD_WORK_CARRY_TO_FILE, ABIE_OP_AND_LITERAL_INTO_WORK,
      ABIE_OP_AND_WORK_WITH_FILE, ABIE_OP_CLEAR_FILE_BIT, ABIE_OP_BRANCH_ON_CARRY_SET,
      ABIE_OP_BRANCH_ON_CARRY_CLEAR, ABIE_OP_BRANCH_ON_NEGATIVE_SET,
      ABIE_OP_BRANCH_ON_NEGATIVE_CLEAR
   } abie_op_t;

   // packed order matches the status byte: n, overflow, z, digit carry, c at bits 4..0
   typedef struct packed {
      logic n;
      logic ovf;
      logic z;
      logic dcy;
      logic c;
   } abie_flags_t;

   typedef struct packed {
      logic [7:0] value;
      abie_flags_t flags;
   } abie_alu_t;

   typedef struct packed {
      abie_op_t op;
      logic dest;
      logic acc;
      logic [2:0] bit_sel;
      logic [7:0] low;
   } abie_decode_t;

   function automatic abie_decode_t abie_decode(input logic [15:0] ins);
      abie_decode_t d;
      d.op = ABIE_OP_NONE;
      d.dest = ins[DEST_POS];
      d.acc = ins[ACC_POS];
      d.bit_sel = ins[BIT_POS +: 3];
      d.low = ins[7:0];
      if (ins[15:10] == OPC_ADD_CARRY) d.op = ABIE_OP_ADD_WORK_CARRY_TO_FILE;
      else if (ins[15:8] == OPC_AND_LIT) d.op = ABIE_OP_AND_LITERAL_INTO_WORK;
      else if (ins[15:10] == OPC_AND_FILE) d.op = ABIE_OP_AND_WORK_WITH_FILE;
      else if (ins[15:12] == OPC_CLR_BIT) d.op = ABIE_OP_CLEAR_FILE_BIT;
      else if (ins[15:8] == OPC_BR_CSET) d.op = ABIE_OP_BRANCH_ON_CARRY_SET;
      else if (ins[15:8] == OPC_BR_CCLR) d.op = ABIE_OP_BRANCH_ON_CARRY_CLEAR;
      else if (ins[15:8] == OPC_BR_NSET) d.op = ABIE_OP_BRANCH_ON_NEGATIVE_SET;
      else if (ins[15:8] == OPC_BR_NCLR) d.op = ABIE_OP_BRANCH_ON_NEGATIVE_CLEAR;
      return d;
   endfunction

   // signed offset doubled, sign-extended to the counter width
   function automatic logic [20:0] abie_branch_offset(input logic [7:0] n);
      return {{12{n[7]}}, n, 1'b0};
   endfunction
endpackage

// ---- hdl/abie_alu.sv ----
// data path: add with carry, and, bit clear, with flag update
`timescale 1ns/100ps
module abie_alu
(
   input wire abie_pkg::abie_op_t i_op,
   input wire logic [7:0] i_work,
   input wire logic [7:0] i_oper,
   input wire logic [2:0] i_bit,
   input wire abie_pkg::abie_flags_t i_flags,
   output abie_pkg::abie_alu_t o_res
);
   logic [8:0] sum;
   logic [4:0] nib;

   always_comb
   begin
      sum = {1'b0, i_work} + {1'b0, i_oper} + {8'h00, i_flags.c};
      nib = {1'b0, i_work[3:0]} + {1'b0, i_oper[3:0]} + {4'h0, i_flags.c};
      o_res.flags = i_flags;
      o_res.value = i_oper;
      unique case (i_op)
         abie_pkg::ABIE_OP_ADD_WORK_CARRY_TO_FILE:
         begin
            o_res.value = sum[7:0];
            o_res.flags.c = sum[8];
            o_res.flags.dcy = nib[4];
            o_res.flags.ovf = (i_work[7] == i_oper[7]) && (sum[7] != i_work[7]);
            o_res.flags.z = (sum[7:0] == 8'h00);
            o_res.flags.n = sum[7];
         end
         abie_pkg::ABIE_OP_AND_LITERAL_INTO_WORK, abie_pkg::ABIE_OP_AND_WORK_WITH_FILE:
         begin
            o_res.value = i_work & i_oper;
            o_res.flags.z = ((i_work & i_oper) == 8'h00);
            o_res.flags.n = i_work[7] & i_oper[7];
         end
         abie_pkg::ABIE_OP_CLEAR_FILE_BIT:
            o_res.value = i_oper & ~(8'h01 << i_bit);
         default:
            o_res.value = i_oper;
      endcase
   end
endmodule // abie_alu

// ---- hdl/abie_exec.sv ----
// instruction executor with register access over axi4-lite
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
module abie_exec
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_busy
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4, ST_N1, ST_N2, ST_N3, ST_N4
   } abie_state_t;

   abie_state_t state;
   logic aw_got;
   logic w_got;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   logic wr_fire;
   logic wr_ok;
   logic [31:0] rd_word;
   logic rd_ok;
   logic [15:0] instr;
   abie_pkg::abie_decode_t dec;
   logic [7:0] work;
   abie_pkg::abie_flags_t flags;
   logic [3:0] bank;
   logic [20:0] pc;
   logic [11:0] fsr;
   logic ext_en;
   logic [11:0] maddr;
   logic [11:0] ea;
   logic [7:0] oper;
   abie_pkg::abie_alu_t res;
   abie_pkg::abie_alu_t alu_out;
   logic taken;
   logic [7:0] mem [0:4095];

   // byte-lane merge of a bus write into a register word
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (st[i]) r[8*i +: 8] = nw[8*i +: 8];
      return r;
   endfunction

   function automatic logic [11:0] eff_addr(input abie_pkg::abie_decode_t d,
                                            input logic [3:0] b, input logic [11:0] f,
                                            input logic x);
      logic [11:0] r;
      r = {b, d.low};
      if (!d.acc)
      begin
         if (x && d.low <= abie_pkg::ACCESS_LIMIT) r = f + {4'h0, d.low};
         else if (d.low <= abie_pkg::ACCESS_LIMIT) r = {abie_pkg::ACCESS_LO_BANK, d.low};
         else r = {abie_pkg::ACCESS_HI_BANK, d.low};
      end
      return r;
   endfunction

   function automatic logic sw_we(input logic fire, input logic [7:0] a,
                                  input logic [7:0] off, input logic idle);
      return fire && (a == off) && idle;
   endfunction

   function automatic logic is_file_op(input abie_pkg::abie_op_t op);
      return op == abie_pkg::ABIE_OP_ADD_WORK_CARRY_TO_FILE ||
             op == abie_pkg::ABIE_OP_AND_WORK_WITH_FILE;
   endfunction

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   assign wr_fire = aw_got && w_got && !o_bvalid;

   always_comb
   begin
      wr_ok = 1'b1;
      unique case (wa)
         abie_pkg::OFF_CTRL, abie_pkg::OFF_INSTR, abie_pkg::OFF_WORK, abie_pkg::OFF_STATUS,
         abie_pkg::OFF_BANK, abie_pkg::OFF_PC, abie_pkg::OFF_FSR, abie_pkg::OFF_MADDR,
         abie_pkg::OFF_MDATA, abie_pkg::OFF_STATE: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= abie_pkg::RESP_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         wa <= 8'h00;
         wd <= 32'h0000_0000;
         ws <= 4'h0;
      end
      else if (i_clk_en)
      begin
         if (i_awvalid && o_awready)
         begin
            aw_got <= 1'b1;
            o_awready <= 1'b0;
            wa <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_got <= 1'b1;
            o_wready <= 1'b0;
            wd <= i_wdata;
            ws <= i_wstrb;
         end
         if (wr_fire)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok ? abie_pkg::RESP_OKAY : abie_pkg::RESP_SLVERR;
         end
         if (o_bvalid && i_bready)
         begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   always_comb
   begin
      rd_ok = 1'b1;
      rd_word = 32'h0000_0000;
      unique case (i_araddr)
         abie_pkg::OFF_CTRL: rd_word = {31'h0, ext_en};
         abie_pkg::OFF_INSTR: rd_word = {16'h0000, instr};
         abie_pkg::OFF_WORK: rd_word = {24'h00_0000, work};
         abie_pkg::OFF_STATUS: rd_word = {27'h000_0000, flags};
         abie_pkg::OFF_BANK: rd_word = {28'h000_0000, bank};
         abie_pkg::OFF_PC: rd_word = {11'h000, pc};
         abie_pkg::OFF_FSR: rd_word = {20'h0_0000, fsr};
         abie_pkg::OFF_MADDR: rd_word = {20'h0_0000, maddr};
         abie_pkg::OFF_MDATA: rd_word = {24'h00_0000, mem[maddr]};
         abie_pkg::OFF_STATE: rd_word = {30'h0, taken, state != ST_IDLE};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= abie_pkg::RESP_OKAY;
      end
      else if (i_clk_en)
      begin
         if (i_arvalid && o_arready)
         begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= rd_ok ? abie_pkg::RESP_OKAY : abie_pkg::RESP_SLVERR;
         end
         else if (o_rvalid && i_rready)
         begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // phase sequencer
   // ------------------------------------------------------------
   // a write to the instruction word launches it; ignored while busy
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state <= ST_IDLE;
         o_busy <= 1'b0;
         instr <= abie_pkg::INSTR_RST;
      end
      else if (i_clk_en)
      begin
         unique case (state)
            ST_IDLE:
               if (sw_we(wr_fire, wa, abie_pkg::OFF_INSTR, 1'b1))
               begin
                  instr <= 16'(wmerge({16'h0000, instr}, wd, ws));
                  state <= ST_Q1;
                  o_busy <= 1'b1;
               end
            ST_Q1: state <= ST_Q2;
            ST_Q2: state <= ST_Q3;
            ST_Q3: state <= ST_Q4;
            ST_Q4:
            begin
               state <= taken ? ST_N1 : ST_IDLE;
               o_busy <= taken;
            end
            ST_N1: state <= ST_N2;
            ST_N2: state <= ST_N3;
            ST_N3: state <= ST_N4;
            ST_N4:
            begin
               state <= ST_IDLE;
               o_busy <= 1'b0;
            end
         endcase
      end
   end

   // decode, operand read, process
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         dec <= '0;
         ea <= 12'h000;
         oper <= 8'h00;
         res <= '0;
         taken <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (state == ST_Q1) dec <= abie_pkg::abie_decode(instr);
         if (state == ST_Q2)
         begin
            ea <= eff_addr(dec, bank, fsr, ext_en);
            oper <= (dec.op == abie_pkg::ABIE_OP_AND_LITERAL_INTO_WORK) ? dec.low :
                    mem[eff_addr(dec, bank, fsr, ext_en)];
         end
         if (state == ST_Q3)
         begin
            res <= alu_out;
            unique case (dec.op)
               abie_pkg::ABIE_OP_BRANCH_ON_CARRY_SET: taken <= flags.c;
               abie_pkg::ABIE_OP_BRANCH_ON_CARRY_CLEAR: taken <= !flags.c;
               abie_pkg::ABIE_OP_BRANCH_ON_NEGATIVE_SET: taken <= flags.n;
               abie_pkg::ABIE_OP_BRANCH_ON_NEGATIVE_CLEAR: taken <= !flags.n;
               default: taken <= 1'b0;
            endcase
         end
      end
   end

   abie_alu u_alu
   (
      .i_op(dec.op),
      .i_work(work),
      .i_oper(oper),
      .i_bit(dec.bit_sel),
      .i_flags(flags),
      .o_res(alu_out)
   );

   // ------------------------------------------------------------
   // architectural state: work, flags, counter, bank, config
   // ------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         work <= abie_pkg::WORK_RST;
         flags <= '0;
      end
      else if (i_clk_en)
      begin
         if (sw_we(wr_fire, wa, abie_pkg::OFF_WORK, state == ST_IDLE))
            work <= 8'(wmerge({24'h00_0000, work}, wd, ws));
         else if (state == ST_Q4 && (dec.op == abie_pkg::ABIE_OP_AND_LITERAL_INTO_WORK ||
                  (is_file_op(dec.op) && !dec.dest)))
            work <= res.value;
         if (sw_we(wr_fire, wa, abie_pkg::OFF_STATUS, state == ST_IDLE))
            flags <= 5'(wmerge({27'h000_0000, flags}, wd, ws));
         else if (state == ST_Q4 && (is_file_op(dec.op) ||
                  dec.op == abie_pkg::ABIE_OP_AND_LITERAL_INTO_WORK))
            flags <= res.flags;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         pc <= abie_pkg::PC_RST;
      else if (i_clk_en)
      begin
         if (sw_we(wr_fire, wa, abie_pkg::OFF_PC, state == ST_IDLE))
            pc <= 21'(wmerge({11'h000, pc}, wd, ws));
         else if (state == ST_Q1)
            pc <= pc + abie_pkg::PC_STEP;
         else if (state == ST_Q4 && taken)
            pc <= pc + abie_pkg::abie_branch_offset(dec.low);
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         bank <= abie_pkg::BANK_RST;
         fsr <= abie_pkg::FSR_RST;
         ext_en <= 1'b0;
         maddr <= 12'h000;
      end
      else if (i_clk_en)
      begin
         if (sw_we(wr_fire, wa, abie_pkg::OFF_BANK, state == ST_IDLE))
            bank <= 4'(wmerge({28'h000_0000, bank}, wd, ws));
         if (sw_we(wr_fire, wa, abie_pkg::OFF_FSR, state == ST_IDLE))
            fsr <= 12'(wmerge({20'h0_0000, fsr}, wd, ws));
         if (sw_we(wr_fire, wa, abie_pkg::OFF_CTRL, state == ST_IDLE))
            ext_en <= 1'(wmerge({31'h0, ext_en}, wd, ws) >> abie_pkg::CTRL_EXT_POS);
         if (sw_we(wr_fire, wa, abie_pkg::OFF_MADDR, state == ST_IDLE))
            maddr <= 12'(wmerge({20'h0_0000, maddr}, wd, ws));
      end
   end

   // data memory has no reset: contents are software's to set up
   always_ff @(posedge i_ref_clk)
   begin
      if (i_clk_en)
      begin
         if (sw_we(wr_fire, wa, abie_pkg::OFF_MDATA, state == ST_IDLE) && ws[0])
            mem[maddr] <= wd[7:0];
         else if (state == ST_Q4 && ((is_file_op(dec.op) && dec.dest) ||
                  dec.op == abie_pkg::ABIE_OP_CLEAR_FILE_BIT))
            mem[ea] <= res.value;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst || !i_clk_en);

   sequence s_phases;
      state == ST_Q1 ##1 state == ST_Q2 ##1 state == ST_Q3 ##1 state == ST_Q4;
   endsequence
   sequence s_nop;
      state == ST_N1 ##1 state == ST_N2 ##1 state == ST_N3 ##1 state == ST_N4;
   endsequence

   phase_order_a: assert property (state == ST_Q1 |-> s_phases)
      else $error("phases out of order");
   taken_nop_a: assert property (state == ST_Q4 && taken |=> s_nop ##1 state == ST_IDLE)
      else $error("taken branch lacks nop cycle");
   no_jump_a: assert property (state == ST_Q4 && !taken |=> state == ST_IDLE)
      else $error("untaken branch took extra cycle");
   branch_target_a: assert property (state == ST_N1 |->
      pc == $past(pc, 4) + abie_pkg::PC_STEP + abie_pkg::abie_branch_offset(dec.low))
      else $error("wrong branch target");
   carry_set_a: assert property (state == ST_Q4 &&
      dec.op == abie_pkg::ABIE_OP_BRANCH_ON_CARRY_SET |-> taken == flags.c)
      else $error("carry-set branch decision wrong");
   carry_clear_a: assert property (state == ST_Q4 &&
      dec.op == abie_pkg::ABIE_OP_BRANCH_ON_CARRY_CLEAR |-> taken == !flags.c)
      else $error("carry-clear branch decision wrong");
   neg_set_a: assert property (state == ST_Q4 &&
      dec.op == abie_pkg::ABIE_OP_BRANCH_ON_NEGATIVE_SET |-> taken == flags.n)
      else $error("negative-set branch decision wrong");
   neg_clear_a: assert property (state == ST_Q4 &&
      dec.op == abie_pkg::ABIE_OP_BRANCH_ON_NEGATIVE_CLEAR |-> taken == !flags.n)
      else $error("negative-clear branch decision wrong");
   add_result_a: assert property (state == ST_Q4 && !dec.dest &&
      dec.op == abie_pkg::ABIE_OP_ADD_WORK_CARRY_TO_FILE |=> {flags.c, work} ==
      9'({1'b0, $past(work)} + {1'b0, $past(oper)} + {8'h00, $past(flags.c)}))
      else $error("add with carry result wrong");
   and_flags_a: assert property (state == ST_Q4 && (dec.op ==
      abie_pkg::ABIE_OP_AND_WORK_WITH_FILE || dec.op == abie_pkg::ABIE_OP_AND_LITERAL_INTO_WORK)
      |=> {flags.ovf, flags.dcy, flags.c} == $past({flags.ovf, flags.dcy, flags.c}))
      else $error("and disturbed other flags");
   bit_clear_a: assert property (state == ST_Q4 && dec.op == abie_pkg::ABIE_OP_CLEAR_FILE_BIT
      |=> $stable(flags) && mem[$past(ea)][$past(dec.bit_sel)] == 1'b0)
      else $error("bit clear failed or touched flags");
   index_mode_a: assert property (state == ST_Q2 && !dec.acc && ext_en &&
      dec.low <= abie_pkg::ACCESS_LIMIT |=> ea == $past(fsr) + {4'h0, $past(dec.low)})
      else $error("indexed operand address wrong");
   bank_mode_a: assert property (state == ST_Q2 && dec.acc |=> ea == $past({bank, dec.low}))
      else $error("banked operand address wrong");
endmodule // abie_exec

// ---- sim/abie_exec_tb.sv ----
// self-checking bench for the add and branch executor
`timescale 1ns/100ps
module abie_exec_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic arv = 1'b0;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic [31:0] seed = 32'h9f4b7b40;
   logic [1:0] bresp, rresp, resp;
   logic awr, wrdy, bv, arr, rv, busy;
   int n_fail = 0;
   int checks_done = 0;
   int bcnt = 0;

   always #5 clk = ~clk;
   always @(posedge clk) if (busy === 1'b1) bcnt <= bcnt + 1;

   // bready and rready are held high: always ready to take an answer
   abie_exec u_dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_awaddr(awa),
      .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv),
      .o_wready(wrdy), .o_bresp(bresp), .o_bvalid(bv), .i_bready(1'b1), .i_araddr(ara),
      .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rv),
      .i_rready(1'b1), .o_busy(busy));

   // ------------------------------------------------------------
   // bus tasks and helpers
   // ------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tmo(input int k);
      if (k >= 50)
      begin
         n_fail++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int k;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wrdy === 1'b1) wv <= 1'b0;
         if (bv === 1'b1) break;
      end
      tmo(k);
      resp = bresp;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int k;
      ara <= a;
      arv <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge clk);
         if (arr === 1'b1) arv <= 1'b0;
         if (rv === 1'b1) break;
      end
      tmo(k);
      d = rdat;
      resp = rresp;
   endtask

   // busy spans four cycles, eight when a branch is taken
   task automatic run(input logic [15:0] ins, input int cyc);
      int b0;
      b0 = bcnt;
      wr(abie_pkg::OFF_INSTR, {16'h0, ins});
      repeat (10) @(posedge clk);
      chk(bcnt - b0, cyc);
   endtask

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [12:0] add_exp(input logic [7:0] w, f, input logic c);
      logic [8:0] s;
      logic hc;
      s = w + f + c;
      hc = (w[3:0] + f[3:0] + c) > 5'h0f;
      return {s[7], (w[7] == f[7]) && (s[7] != w[7]), s[7:0] == 8'h00, hc, s[8], s[7:0]};
   endfunction

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial
   begin
      logic [7:0] bo [4] = '{abie_pkg::OPC_BR_CSET, abie_pkg::OPC_BR_CCLR,
         abie_pkg::OPC_BR_NSET, abie_pkg::OPC_BR_NCLR};
      logic [7:0] w, f, m, r;
      logic [4:0] s, fl;
      logic [3:0] b;
      logic [11:0] fsr, ma;
      logic [20:0] p;
      logic [31:0] v;
      logic [12:0] e;
      logic [15:0] ins;
      logic a, d, x, tk;
      int i, k;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(abie_pkg::OFF_PC, v);
      chk(v, 32'h0);
      rd(8'h3c, v);
      chk({resp, v[1:0]}, {abie_pkg::RESP_SLVERR, 2'h0});
      wr(8'h3c, 32'h0);
      chk(resp, abie_pkg::RESP_SLVERR);
      run(16'hffff, 4);
      rd(abie_pkg::OFF_PC, v);
      chk(v, {11'h0, abie_pkg::PC_STEP});
      for (i = 0; i < 40; i++)
      begin
         {w, f, m, b, a, d, x} = 31'(rnd());
         {s, fsr} = 17'(rnd());
         k = i % 4;
         if (i < 4) f = i[0] ? 8'h5f : 8'h60;
         ma = a ? {b, f} : (x && f <= 8'h5f) ? fsr + f : {f > 8'h5f ? 4'hf : 4'h0, f};
         e = add_exp(w, m, s[0]);
         r = k == 0 ? e[7:0] : k == 2 ? (m & ~(8'h01 << b[2:0])) : w & (k == 1 ? m : f);
         fl = k == 0 ? e[12:8] : k == 2 ? s : {r[7], s[3], r == 8'h00, s[1:0]};
         ins = k == 0 ? {abie_pkg::OPC_ADD_CARRY, d, a, f} : k == 1 ?
            {abie_pkg::OPC_AND_FILE, d, a, f} : {abie_pkg::OPC_CLR_BIT, b[2:0], a, f};
         if (k == 3) ins = {abie_pkg::OPC_AND_LIT, f};
         d = k == 2 ? 1'b1 : k == 3 ? 1'b0 : d;
         wr(abie_pkg::OFF_CTRL, {31'h0, x});
         wr(abie_pkg::OFF_FSR, {20'h0, fsr});
         wr(abie_pkg::OFF_WORK, {24'h0, w});
         wr(abie_pkg::OFF_STATUS, {27'h0, s});
         wr(abie_pkg::OFF_BANK, {28'h0, b});
         wr(abie_pkg::OFF_MADDR, {20'h0, ma});
         wr(abie_pkg::OFF_MDATA, {24'h0, m});
         chk(resp, abie_pkg::RESP_OKAY);
         run(ins, 4);
         rd(abie_pkg::OFF_WORK, v);
         chk(v, {24'h0, d ? w : r});
         rd(abie_pkg::OFF_STATUS, v);
         chk(v, {27'h0, fl});
         rd(abie_pkg::OFF_MDATA, v);
         chk(v, {24'h0, d ? r : m});
      end
      for (i = 0; i < 16; i++)
      begin
         {s, w} = 13'(rnd());
         if (i < 2) w = i[0] ? 8'h7f : 8'h80;
         s[0] = i[0];
         s[4] = i[0];
         tk = (i / 2) % 2 == 0 ? i[0] : !i[0];
         wr(abie_pkg::OFF_STATUS, {27'h0, s});
         rd(abie_pkg::OFF_PC, v);
         p = v[20:0] + 21'h2 + (tk ? {{12{w[7]}}, w, 1'b0} : 21'h0);
         run({bo[(i / 2) % 4], w}, tk ? 8 : 4);
         rd(abie_pkg::OFF_PC, v);
         chk(v, {11'h0, p});
         rd(abie_pkg::OFF_STATE, v);
         chk(v, {30'h0, tk, 1'b0});
      end
      end_sim();
   end
endmodule // abie_exec_tb
